//--- cycle_timing_defs.svh
// timing constants for the bus cycle state sequencer
// assumes inclusion by name from the package and modules
`ifndef CYCLE_TIMING_DEFS_SVH
`define CYCLE_TIMING_DEFS_SVH

`define ST_ONCHIP_MEM     8'h02
`define ST_SUP8_WORD      8'h06
`define ST_SUP8_BYTE      8'h03
`define ST_SUP16          8'h03
`define ST_EXT8_2ST_WORD  8'h04
`define ST_EXT8_2ST_BYTE  8'h02
`define ST_EXT8_3ST_WORD  8'h06
`define ST_EXT8_3ST_BYTE  8'h03
`define ST_EXT16_2ST      8'h02
`define ST_EXT16_3ST      8'h03
`define ST_INTERNAL       8'h01
`define WAIT_W            3
`define COUNT_W           8

`endif

//--- cycle_timing_pkg.sv
// types shared by the bus cycle state sequencer modules
// assumes cycle_timing_defs.svh is on the include path
`include "cycle_timing_defs.svh"

package cycle_timing_pkg;

	typedef enum logic [2:0] {
		CYC_FETCH   = 3'h0,
		CYC_BRADDR  = 3'h1,
		CYC_STACK   = 3'h2,
		CYC_BYTE    = 3'h3,
		CYC_WORD    = 3'h4,
		CYC_INTERNAL = 3'h5
	} cycle_kind_e;

	typedef enum logic [1:0] {
		AREA_ONCHIP_MEM = 2'h0,
		AREA_SUPPORT    = 2'h1,
		AREA_EXTERNAL   = 2'h2
	} area_e;

	typedef enum logic [3:0] {
		INS_ADD_B_IMM    = 4'h0,
		INS_ADD_B_REG    = 4'h1,
		INS_ADD_W_IMM    = 4'h2,
		INS_ADD_W_REG    = 4'h3,
		INS_ADD_L_IMM    = 4'h4,
		INS_ADD_L_REG    = 4'h5,
		INS_ADD_CONST    = 4'h6,
		INS_ADD_CARRY    = 4'h7,
		INS_AND_B        = 4'h8,
		INS_AND_W_IMM    = 4'h9,
		INS_AND_L_IMM    = 4'hA,
		INS_AND_L_REG    = 4'hB,
		INS_AND_CC       = 4'hC,
		INS_BIT_AND_REG  = 4'hD,
		INS_BIT_AND_MEM  = 4'hE,
		INS_BRANCH_D8    = 4'hF
	} instr_e;

	typedef logic [`COUNT_W-1:0] count_t;

endpackage

//--- cycle_req_if.sv
// request and answer between the sequencer and its state lookup
// assumes one clock domain; purely combinational lookup
`timescale 1ns/1ps
`include "cycle_timing_defs.svh"

interface cycle_req_if;
	import cycle_timing_pkg::*;
	cycle_kind_e           kind;
	area_e                 area;
	logic                  bus16;
	logic                  three_state;
	logic [`WAIT_W-1:0]    waits;
	count_t                states;

	modport requester (output kind, area, bus16, three_state, waits,
		input states);
	modport lookup (input kind, area, bus16, three_state, waits,
		output states);
endinterface

//--- cycle_state_lookup.sv
// per-cycle state count for a cycle kind, area and bus setting
// assumes the requester holds its inputs stable when it reads states
`timescale 1ns/1ps
`include "cycle_timing_defs.svh"

module cycle_state_lookup
	import cycle_timing_pkg::*;
(
	cycle_req_if.lookup req
);

	function automatic count_t waited(input count_t base,
		input logic [`WAIT_W-1:0] m, input logic dbl);
		count_t add;
		add = count_t'(m);
		if (dbl)
			add = count_t'(add << 1);
		return count_t'(base + add);
	endfunction

	always_comb begin
		req.states = `ST_INTERNAL;
		if (req.kind == CYC_INTERNAL) begin
			req.states = `ST_INTERNAL;
		end else if (req.area == AREA_ONCHIP_MEM) begin
			req.states = `ST_ONCHIP_MEM;
		end else if (req.area == AREA_SUPPORT) begin
			if (req.bus16)
				req.states = `ST_SUP16;
			else if (req.kind == CYC_BYTE)
				req.states = `ST_SUP8_BYTE;
			else
				req.states = `ST_SUP8_WORD;
		end else if (req.bus16) begin
			// 16-bit external: data same as fetch
			if (req.three_state)
				req.states = waited(`ST_EXT16_3ST, req.waits, 1'b0);
			else
				req.states = `ST_EXT16_2ST;
		end else if (req.kind == CYC_BYTE) begin
			if (req.three_state)
				req.states = waited(`ST_EXT8_3ST_BYTE, req.waits, 1'b0);
			else
				req.states = `ST_EXT8_2ST_BYTE;
		end else begin
			if (req.three_state)
				req.states = waited(`ST_EXT8_3ST_WORD, req.waits, 1'b1);
			else
				req.states = `ST_EXT8_2ST_WORD;
		end
	end

endmodule

//--- instr_cycle_table.sv
// cycle counts per instruction form: fetch and byte data cycles
// assumes only the listed forms; others get one fetch and no byte cycles
`timescale 1ns/1ps

module instr_cycle_table
	import cycle_timing_pkg::*;
(
	input  instr_e     instr,
	output logic [1:0] fetches,
	output logic [1:0] byte_cycles
);

	always_comb begin
		fetches     = 2'h1;
		byte_cycles = 2'h0;
		unique case (instr)
			INS_ADD_W_IMM, INS_AND_W_IMM: fetches = 2'h2;
			INS_ADD_L_IMM, INS_AND_L_IMM: fetches = 2'h3;
			INS_AND_L_REG:                fetches = 2'h2;
			INS_BRANCH_D8:                fetches = 2'h2;
			INS_BIT_AND_MEM: begin
				fetches     = 2'h2;
				byte_cycles = 2'h1;
			end
			INS_ADD_CONST, INS_ADD_CARRY, INS_AND_CC:
				fetches = 2'h1;
			INS_ADD_B_IMM, INS_ADD_B_REG, INS_ADD_W_REG, INS_ADD_L_REG,
			INS_AND_B, INS_BIT_AND_REG:
				fetches = 2'h1;
		endcase
	end

endmodule

//--- cycle_sequencer.sv
// executes one instruction as a run of timed bus cycles
// assumes start is pulsed only while ready is high
`timescale 1ns/1ps
`include "cycle_timing_defs.svh"

module cycle_sequencer
	import cycle_timing_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               arst_n,
	input  wire logic               start,
	input  wire instr_e             instr,
	input  wire area_e              code_area,
	input  wire area_e              data_area,
	input  wire logic               sup_bus16,
	input  wire logic               ext_bus16,
	input  wire logic               ext_three_state,
	input  wire logic [`WAIT_W-1:0] wait_states,
	output logic                    ready,
	output logic                    bus_active,
	output logic                    data_phase,
	output logic                    done,
	output count_t                  total_states
);

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FETCH = 3'b010,
		ST_DATA  = 3'b100
	} seq_state_e;

	seq_state_e         state_q;
	logic [1:0]         fetch_left_q;
	logic [1:0]         byte_left_q;
	count_t             tick_q;
	count_t             acc_q;
	instr_e             instr_q;
	area_e              code_area_q;
	area_e              data_area_q;
	logic               sup16_q;
	logic               ext16_q;
	logic               ext3_q;
	logic [`WAIT_W-1:0] waits_q;
	logic [1:0]         tbl_fetches;
	logic [1:0]         tbl_bytes;
	logic               last_state;

	cycle_req_if req ();

	cycle_state_lookup u_lookup (
		.req (req.lookup)
	);

	instr_cycle_table u_table (
		.instr       (instr_q),
		.fetches     (tbl_fetches),
		.byte_cycles (tbl_bytes)
	);

	always_comb begin
		req.kind = (state_q == ST_DATA) ? CYC_BYTE : CYC_FETCH;
		req.area = (state_q == ST_DATA) ? data_area_q : code_area_q;
		req.bus16 = (req.area == AREA_EXTERNAL) ? ext16_q : sup16_q;
		req.three_state = ext3_q;
		req.waits = waits_q;
	end

	assign last_state = (tick_q == count_t'(req.states - count_t'(1)));

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			instr_q     <= INS_ADD_B_REG;
			code_area_q <= AREA_ONCHIP_MEM;
			data_area_q <= AREA_ONCHIP_MEM;
			sup16_q     <= 1'b0;
			ext16_q     <= 1'b0;
			ext3_q      <= 1'b0;
			waits_q     <= '0;
		end else if (start && state_q == ST_IDLE) begin
			instr_q     <= instr;
			code_area_q <= code_area;
			data_area_q <= data_area;
			sup16_q     <= sup_bus16;
			ext16_q     <= ext_bus16;
			ext3_q      <= ext_three_state;
			waits_q     <= wait_states;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q      <= ST_IDLE;
			tick_q       <= '0;
			fetch_left_q <= 2'h0;
			byte_left_q  <= 2'h0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					tick_q <= '0;
					if (start) begin
						state_q      <= ST_FETCH;
						fetch_left_q <= 2'h0;
						byte_left_q  <= 2'h0;
					end
				end
				ST_FETCH: begin
					if (tick_q == '0 && fetch_left_q == 2'h0) begin
						// first state: load the counts from the table
						fetch_left_q <= tbl_fetches;
						byte_left_q  <= tbl_bytes;
					end
					if (last_state) begin
						tick_q <= '0;
						if (fetch_left_q <= 2'h1 && !(tick_q == '0
							&& fetch_left_q == 2'h0 && tbl_fetches > 2'h1)) begin
							fetch_left_q <= 2'h0;
							state_q <= (byte_left_q != 2'h0
								|| (fetch_left_q == 2'h0 && tbl_bytes != 2'h0))
								? ST_DATA : ST_IDLE;
							if (fetch_left_q == 2'h0)
								byte_left_q <= tbl_bytes;
						end else if (fetch_left_q == 2'h0) begin
							fetch_left_q <= 2'(tbl_fetches - 2'h1);
						end else begin
							fetch_left_q <= 2'(fetch_left_q - 2'h1);
						end
					end else begin
						tick_q <= count_t'(tick_q + count_t'(1));
					end
				end
				ST_DATA: begin
					if (last_state) begin
						tick_q      <= '0;
						byte_left_q <= 2'(byte_left_q - 2'h1);
						if (byte_left_q == 2'h1)
							state_q <= ST_IDLE;
					end else begin
						tick_q <= count_t'(tick_q + count_t'(1));
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// state total accumulates one per bus state
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			acc_q <= '0;
		end else if (state_q == ST_IDLE) begin
			acc_q <= '0;
		end else begin
			acc_q <= count_t'(acc_q + count_t'(1));
		end
	end

	logic finishing;
	assign finishing = (state_q != ST_IDLE) && last_state
		&& ((state_q == ST_DATA && byte_left_q == 2'h1)
		|| (state_q == ST_FETCH && (fetch_left_q == 2'h1
		|| (fetch_left_q == 2'h0 && tick_q == '0 && tbl_fetches == 2'h1)
		|| (fetch_left_q == 2'h0 && tick_q != '0))
		&& byte_left_q == 2'h0
		&& !(fetch_left_q == 2'h0 && tbl_bytes != 2'h0)));

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ready        <= 1'b1;
			bus_active   <= 1'b0;
			data_phase   <= 1'b0;
			done         <= 1'b0;
			total_states <= '0;
		end else begin
			done <= finishing;
			if (finishing)
				total_states <= count_t'(acc_q + count_t'(1));
			ready <= (state_q == ST_IDLE && !start) || finishing;
			bus_active <= (state_q == ST_IDLE) ? start : !finishing;
			data_phase <= (state_q == ST_DATA) && !finishing
				|| (state_q == ST_FETCH && last_state && !finishing
				&& (byte_left_q != 2'h0 || (fetch_left_q == 2'h0
				&& tbl_bytes != 2'h0)) && fetch_left_q <= 2'h1
				&& !(fetch_left_q == 2'h0 && tbl_fetches > 2'h1));
		end
	end

	property p_done_pulse;
		@(posedge clock) disable iff (!arst_n)
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done lasted more than one cycle");

	property p_onchip_fetch;
		@(posedge clock) disable iff (!arst_n)
		(state_q == ST_FETCH && req.area == AREA_ONCHIP_MEM)
			|-> req.states == 8'h02;
	endproperty
	a_onchip_fetch: assert property (p_onchip_fetch)
		else $error("on-chip fetch not two states");

	property p_ext8_word_wait;
		@(posedge clock) disable iff (!arst_n)
		(state_q == ST_FETCH && req.area == AREA_EXTERNAL && !ext16_q
			&& ext3_q) |-> req.states == count_t'(6 + 2 * waits_q);
	endproperty
	a_ext8_word_wait: assert property (p_ext8_word_wait)
		else $error("8-bit three-state fetch count wrong");

	property p_byte_ext8;
		@(posedge clock) disable iff (!arst_n)
		(state_q == ST_DATA && data_area_q == AREA_EXTERNAL && !ext16_q)
			|-> req.states == (ext3_q ? count_t'(3 + waits_q) : 8'h02);
	endproperty
	a_byte_ext8: assert property (p_byte_ext8)
		else $error("8-bit external byte count wrong");

	property p_ext16_same;
		@(posedge clock) disable iff (!arst_n)
		(state_q != ST_IDLE && req.area == AREA_EXTERNAL && ext16_q)
			|-> req.states == (ext3_q ? count_t'(3 + waits_q) : 8'h02);
	endproperty
	a_ext16_same: assert property (p_ext16_same)
		else $error("16-bit external count wrong");

	property p_sup_byte;
		@(posedge clock) disable iff (!arst_n)
		(state_q == ST_DATA && data_area_q == AREA_SUPPORT && !sup16_q)
			|-> req.states == 8'h03;
	endproperty
	a_sup_byte: assert property (p_sup_byte)
		else $error("support module byte count wrong");

	property p_branch_total;
		@(posedge clock) disable iff (!arst_n)
		(done && instr_q == INS_BRANCH_D8 && code_area_q == AREA_ONCHIP_MEM)
			|-> total_states == 8'h04;
	endproperty
	a_branch_total: assert property (p_branch_total)
		else $error("short branch total wrong");

	property p_long_imm_total;
		@(posedge clock) disable iff (!arst_n)
		(done && instr_q == INS_ADD_L_IMM && code_area_q == AREA_ONCHIP_MEM)
			|-> total_states == 8'h06;
	endproperty
	a_long_imm_total: assert property (p_long_imm_total)
		else $error("long immediate add total wrong");

	sequence s_start_idle;
		start && state_q == ST_IDLE;
	endsequence
	property p_start_busy;
		@(posedge clock) disable iff (!arst_n)
		s_start_idle |=> bus_active && state_q == ST_FETCH;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("start did not begin a fetch");

	property p_data_phase;
		@(posedge clock) disable iff (!arst_n)
		data_phase == (state_q == ST_DATA);
	endproperty
	a_data_phase: assert property (p_data_phase)
		else $error("data phase flag out of step with data cycle");

	property p_ready_idle;
		@(posedge clock) disable iff (!arst_n)
		ready |-> state_q == ST_IDLE;
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("ready high while a cycle runs");

	sequence s_start_busy;
		start && state_q != ST_IDLE;
	endsequence
	property p_refused;
		@(posedge clock) disable iff (!arst_n)
		s_start_busy |=> $stable(instr_q) && $stable(waits_q)
			&& $stable(code_area_q);
	endproperty
	a_refused: assert property (p_refused)
		else $error("start taken while busy");

	sequence s_done_onchip;
		done && code_area_q == AREA_ONCHIP_MEM
			&& data_area_q == AREA_ONCHIP_MEM;
	endsequence
	property p_bit_and_total;
		@(posedge clock) disable iff (!arst_n)
		s_done_onchip ##0 (instr_q == INS_BIT_AND_MEM)
			|-> total_states == 8'h06;
	endproperty
	a_bit_and_total: assert property (p_bit_and_total)
		else $error("bit-and memory total wrong");

	property p_and_long_reg_total;
		@(posedge clock) disable iff (!arst_n)
		s_done_onchip ##0 (instr_q == INS_AND_L_REG)
			|-> total_states == 8'h04;
	endproperty
	a_and_long_reg_total: assert property (p_and_long_reg_total)
		else $error("long register and total wrong");

	property p_one_fetch_total;
		@(posedge clock) disable iff (!arst_n)
		s_done_onchip ##0 (instr_q == INS_ADD_CARRY
			|| instr_q == INS_ADD_CONST || instr_q == INS_AND_CC)
			|-> total_states == 8'h02;
	endproperty
	a_one_fetch_total: assert property (p_one_fetch_total)
		else $error("single fetch form total wrong");

endmodule

//--- bus_area_model.sv
// far-side timing model: states per bus cycle for one area and bus setup
// assumes purely combinational use by the bench, inputs held while read
`timescale 1ns/1ps
`include "cycle_timing_defs.svh"

module bus_area_model
	import cycle_timing_pkg::*;
(
	input  wire area_e              area,
	input  wire logic               sup_bus16,
	input  wire logic               ext_bus16,
	input  wire logic               three_st,
	input  wire logic [`WAIT_W-1:0] m,
	output logic [7:0]              fetch_st,
	output logic [7:0]              byte_st
);
	logic [7:0] mw;

	// waits only stretch three-state external access
	assign mw = three_st ? 8'(m) : 8'h00;

	always_comb begin
		case (area)
		AREA_ONCHIP_MEM: begin
			fetch_st = 8'h02;
			byte_st  = 8'h02;
		end
		AREA_SUPPORT: begin
			fetch_st = sup_bus16 ? 8'h03 : 8'h06;
			byte_st  = 8'h03;
		end
		default: begin
			if (ext_bus16) begin
				fetch_st = three_st ? 8'h03 + mw : 8'h02;
				byte_st  = fetch_st;
			end else begin
				fetch_st = three_st ? 8'h06 + 8'h02 * mw : 8'h04;
				byte_st  = three_st ? 8'h03 + mw : 8'h02;
			end
		end
		endcase
	end
endmodule

//--- cycle_bus_timing_tb.sv
// self-checking bench for the bus cycle state sequencer
// assumes cycle_timing_pkg and bus_area_model are compiled first
`timescale 1ns/1ps
`include "cycle_timing_defs.svh"

module cpu_bus_cycle_state_timing_tb
	import cycle_timing_pkg::*;
;
	logic               clock;
	logic               arst_n;
	logic               start;
	instr_e             instr;
	area_e              code_area;
	area_e              data_area;
	logic               sup_bus16;
	logic               ext_bus16;
	logic               ext_three_state;
	logic [`WAIT_W-1:0] wait_states;
	logic               ready;
	logic               bus_active;
	logic               data_phase;
	logic               done;
	count_t             total_states;
	area_e              cfg_ca;
	area_e              cfg_da;
	logic               cfg_s16;
	logic               cfg_e16;
	logic               cfg_ts;
	logic [`WAIT_W-1:0] cfg_m;
	logic [7:0]         code_f;
	logic [7:0]         data_b;
	int                 n_fail;
	int                 n_compared;
	int                 ticks;
	// fetch cycles per form code, in code order
	localparam int FETCH[16] = '{1, 1, 2, 1, 3, 1, 1, 1,
		1, 2, 3, 2, 1, 1, 2, 2};

	cycle_sequencer dut (.clock(clock), .arst_n(arst_n), .start(start),
		.instr(instr), .code_area(code_area), .data_area(data_area),
		.sup_bus16(sup_bus16), .ext_bus16(ext_bus16),
		.ext_three_state(ext_three_state), .wait_states(wait_states),
		.ready(ready), .bus_active(bus_active), .data_phase(data_phase),
		.done(done), .total_states(total_states));

	bus_area_model code_side (.area(cfg_ca), .sup_bus16(cfg_s16),
		.ext_bus16(cfg_e16), .three_st(cfg_ts), .m(cfg_m),
		.fetch_st(code_f), .byte_st());
	bus_area_model data_side (.area(cfg_da), .sup_bus16(cfg_s16),
		.ext_bus16(cfg_e16), .three_st(cfg_ts), .m(cfg_m),
		.fetch_st(), .byte_st(data_b));

	always #25 clock = ~clock;

	task automatic end_of_test();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		ticks++;
		if (ticks >= 40000) begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// entered just after an edge; start is raised at once, so calls
	// chained with no idle land start in the cycle done is high
	task automatic run(input instr_e i, input area_e ca, input area_e da,
		input logic s16, input logic e16, input logic ts,
		input logic [`WAIT_W-1:0] m, input bit poke);
		int cyc;
		int n;
		int nd;
		int dph;
		cfg_ca = ca;
		cfg_da = da;
		cfg_s16 = s16;
		cfg_e16 = e16;
		cfg_ts = ts;
		cfg_m = m;
		start <= 1'b1;
		instr <= i;
		code_area <= ca;
		data_area <= da;
		sup_bus16 <= s16;
		ext_bus16 <= e16;
		ext_three_state <= ts;
		wait_states <= m;
		#1;
		n = FETCH[i] * code_f;
		nd = 0;
		if (i == INS_BIT_AND_MEM) begin
			n = n + data_b;
			nd = data_b;
		end
		@(posedge clock);
		// scramble inputs after the taking edge: they must be latched
		start <= poke;
		instr <= INS_ADD_L_IMM;
		wait_states <= ~m;
		ext_three_state <= ~ts;
		#1;
		cyc = 0;
		dph = 0;
		while (done !== 1'b1 && cyc < 300) begin
			@(posedge clock);
			cyc++;
			start <= 1'b0;
			#1;
			if (data_phase === 1'b1)
				dph++;
			if (cyc == 1) begin
				check("ready_busy", ready, 16'h0000);
				check("bus_active", bus_active, 16'h0001);
			end
		end
		check("latency", cyc, n);
		check("total_states", total_states, n);
		check("ready_done", ready, 16'h0001);
		check("bus_idle", bus_active, 16'h0000);
		check("data_cycles", dph, nd);
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask

	task automatic t_forms();
		for (int k = 0; k < 16; k++) begin
			run(instr_e'(k), AREA_ONCHIP_MEM, AREA_ONCHIP_MEM,
				1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
		end
	endtask

	task automatic t_sweep();
		for (int ca = 0; ca < 3; ca++)
			for (int da = 0; da < 3; da++)
				for (int c = 0; c < 12; c++) begin
					run(INS_BIT_AND_MEM, area_e'(ca[1:0]), area_e'(da[1:0]),
						c[0], c[1], c[2] | c[3],
						c[3] ? 3'h7 : 3'h1, 1'b0);
					idle(c[0] ? 1 : 0);
				end
	endtask

	task automatic t_refused();
		run(INS_ADD_L_IMM, AREA_EXTERNAL, AREA_EXTERNAL,
			1'b0, 1'b0, 1'b1, 3'h5, 1'b1);
	endtask

	task automatic t_reset_mid();
		start <= 1'b1;
		instr <= INS_BIT_AND_MEM;
		code_area <= AREA_EXTERNAL;
		@(posedge clock);
		start <= 1'b0;
		idle(3);
		arst_n <= 1'b0;
		#1;
		check("rst_ready", ready, 16'h0001);
		check("rst_active", bus_active, 16'h0000);
		check("rst_done", done, 16'h0000);
		check("rst_total", total_states, 16'h0000);
		check("rst_phase", data_phase, 16'h0000);
		@(posedge clock);
		arst_n <= 1'b1;
		#1;
		run(INS_BRANCH_D8, AREA_SUPPORT, AREA_SUPPORT,
			1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
	endtask

	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		start = 1'b0;
		instr = INS_ADD_B_IMM;
		code_area = AREA_ONCHIP_MEM;
		data_area = AREA_ONCHIP_MEM;
		sup_bus16 = 1'b0;
		ext_bus16 = 1'b0;
		ext_three_state = 1'b0;
		wait_states = 3'h0;
		n_fail = 0;
		n_compared = 0;
		ticks = 0;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		idle(1);
		t_forms();
		t_sweep();
		t_refused();
		t_reset_mid();
		idle(2);
		end_of_test();
	end
endmodule
